// File: core/spi_port.sv
// How it works
// - target role: select is input; low enables port and MISO drive, high idles everything.
// - target role: select high resets bit counter and drops partial byte.
// - controller with select as output: select pin ignored by serial logic.
// - controller with select input low: leave controller role, set done flag.
// - after select event target role stays until software sets controller_select.
// - each bit driven on one sck edge, sampled on the opposite one.
// - clock_idle_level sets sck idle level and leading edge direction.
// - clock_phase_select picks sampling on leading or trailing edge.
// - bit_order_select one sends lsb first, zero sends msb first.
// - nothing shifts unless port_enable is one.
// - controller_select one picks controller role, zero picks target role.
// - controller sck divider 4,16,64,128, or 2,8,32,64 when doubled.
// - rate bits have no effect in target role.
// - doubling makes shortest sck period two system clocks.
// - each completed byte sets transfer_done_flag.
// - interrupt request while done flag, irq enable and global enable set.
// - done flag cleared by vector taken, or status read then data access.
// - data write during transfer sets collision flag; cleared by status read then data access, not by vector taken.
// - status bits 5 to 1 read zero.
// - data write starts transmission; data read returns receive buffer.
// - controller shifts eight bits then stops; select never driven by hardware.
// - single transmit buffer, double receive buffer; unread byte overwritten.
// - target with select high: MISO released, no shifting, data loads allowed.
`timescale 1ns/1ps
module spi_port
  import spi_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // interrupt hookup to the core
  input wire logic i_global_irq_en,
  input wire logic i_vector_taken,
  output logic o_irq,
  // select pin direction as configured by the port logic
  input wire logic i_sel_is_output,
  // serial pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_sel_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] ctrl;
    logic dbl;
    logic done;
    logic write_collision_flag;
    logic arm_done;
    logic arm_write_collision_flag;
    logic [7:0] rx_buf;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [4:0] edges;
    logic busy;
    logic sck_lvl;
    logic out_bit;
    logic [PIN_COUNT-1:0][SYNC_STAGES-1:0] sync;
    logic [PIN_COUNT-1:0] filt;
    logic [PIN_COUNT-1:0] filt_prev;
    logic [7:0] rdata;
  } port_state_t;

  port_state_t q;
  port_state_t d;

  spi_rate_if rate ();

  spi_rate_div u_rate_div (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .rate(rate.div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode of control bits and pin events

  logic en;
  logic controller_select;
  logic clock_idle_level;
  logic clock_phase_select;
  logic lsb_first;
  logic [PIN_COUNT-1:0] pin_in;
  logic sck_rise;
  logic sck_fall;
  logic sel_low;
  logic tgt_active;
  logic tgt_lead;
  logic tgt_trail;
  logic tgt_sample;
  logic tgt_setup;
  logic ctl_edge;
  logic ctl_lead;
  logic ctl_sample;
  logic ctl_setup;
  logic in_bit;
  logic [7:0] shifted;
  logic in_progress;
  logic mode_fault;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_ctrl;
  logic rd_stat;
  logic rd_data;
  logic [7:0] status_val;

  function automatic logic tx_bit(input logic [7:0] b, input logic lsb);
    tx_bit = lsb ? b[0] : b[7];
  endfunction

  assign en = q.ctrl[CTRL_PORT_EN];
  assign controller_select = q.ctrl[CTRL_MASTER];
  assign clock_idle_level = q.ctrl[CTRL_IDLE_LVL];
  assign clock_phase_select = q.ctrl[CTRL_PHASE];
  assign lsb_first = q.ctrl[CTRL_BIT_ORDER];

  assign pin_in[PIN_SCK] = i_sck;
  assign pin_in[PIN_MOSI] = i_mosi;
  assign pin_in[PIN_SEL] = i_sel_n;
  assign pin_in[PIN_MISO] = i_miso;

  // edges are taken from the filtered copies only
  assign sck_rise = q.filt[PIN_SCK] & ~q.filt_prev[PIN_SCK];
  assign sck_fall = ~q.filt[PIN_SCK] & q.filt_prev[PIN_SCK];
  assign sel_low = ~q.filt[PIN_SEL];

  // target side: leading edge leaves the idle level
  assign tgt_active = en & ~controller_select & sel_low;
  assign tgt_lead = clock_idle_level ? sck_fall : sck_rise;
  assign tgt_trail = clock_idle_level ? sck_rise : sck_fall;
  assign tgt_sample = tgt_active & (clock_phase_select ? tgt_trail : tgt_lead);
  assign tgt_setup = tgt_active & (clock_phase_select ? tgt_lead : tgt_trail);

  // controller side: even edge numbers are leading edges
  assign ctl_edge = en & controller_select & q.busy & rate.tick;
  assign ctl_lead = ~q.edges[0];
  assign ctl_sample = ctl_edge & (clock_phase_select ? ~ctl_lead : ctl_lead);
  assign ctl_setup = ctl_edge & (clock_phase_select ? ctl_lead : ~ctl_lead);

  // divider only runs in controller role, so rate bits are inert in target role
  assign rate.run = en & controller_select & q.busy;
  assign rate.rate_code = {q.dbl, q.ctrl[CTRL_RATE_HI], q.ctrl[CTRL_RATE_LO]};

  assign in_bit = controller_select ? q.filt[PIN_MISO] : q.filt[PIN_MOSI];
  assign shifted = lsb_first ? {in_bit, q.shreg[7:1]} : {q.shreg[6:0], in_bit};
  assign in_progress = controller_select ? q.busy : (q.bitcnt != 4'h0);

  // another controller pulled select low while we drive the bus
  assign mode_fault = en & controller_select & ~i_sel_is_output & sel_low;

  assign wr_ctrl = i_wr & (i_addr == ADDR_CTRL);
  assign wr_stat = i_wr & (i_addr == ADDR_STAT);
  assign wr_data = i_wr & (i_addr == ADDR_DATA);
  assign rd_ctrl = i_rd & (i_addr == ADDR_CTRL);
  assign rd_stat = i_rd & (i_addr == ADDR_STAT);
  assign rd_data = i_rd & (i_addr == ADDR_DATA);

  assign status_val = {q.done, q.write_collision_flag, 5'h00, q.dbl};

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;

    // three stage synchronisers, a change counts once stages two and three agree
    for (int p = 0; p < PIN_COUNT; p++) begin
      d.sync[p] = {q.sync[p][SYNC_STAGES-2:0], pin_in[p]};
      if (q.sync[p][1] == q.sync[p][2]) begin
        d.filt[p] = q.sync[p][2];
      end
    end
    d.filt_prev = q.filt;

    // read data, one cycle after the strobe
    d.rdata = 8'h00;
    if (rd_ctrl) begin
      d.rdata = q.ctrl;
    end
    if (rd_stat) begin
      d.rdata = status_val;
    end
    if (rd_data) begin
      d.rdata = q.rx_buf;
    end

    // flag clearing: status read with a flag set, then a data access
    if (rd_stat) begin
      d.arm_done = q.done;
      d.arm_write_collision_flag = q.write_collision_flag;
    end
    if ((rd_data || wr_data) && (q.arm_done || q.arm_write_collision_flag)) begin
      d.done = 1'b0;
      if (q.arm_write_collision_flag) begin
        d.write_collision_flag = 1'b0;
      end
      d.arm_done = 1'b0;
      d.arm_write_collision_flag = 1'b0;
    end
    if (i_vector_taken) begin
      d.done = 1'b0;
    end

    // control writes
    if (wr_ctrl) begin
      d.ctrl = i_wdata;
    end
    if (wr_stat) begin
      d.dbl = i_wdata[STAT_DOUBLE];
    end

    // target role: select high holds the shifter in reset
    if (!controller_select) begin
      if (!tgt_active) begin
        d.bitcnt = 4'h0;
        d.out_bit = tx_bit(q.shreg, lsb_first);
      end else begin
        if (tgt_sample) begin
          d.shreg = shifted;
          d.bitcnt = q.bitcnt + 4'h1;
          if (q.bitcnt == (BITS_PER_BYTE - 4'h1)) begin
            d.rx_buf = shifted;
            d.done = 1'b1;
            d.bitcnt = 4'h0;
          end
        end
        if (tgt_setup) begin
          d.out_bit = tx_bit(q.shreg, lsb_first);
        end
      end
    end

    // controller role: one tick per sck half period, sixteen edges per byte
    if (ctl_edge) begin
      d.sck_lvl = ~q.sck_lvl;
      d.edges = q.edges + 5'h01;
      if (ctl_sample) begin
        d.shreg = shifted;
      end
      if (ctl_setup) begin
        d.out_bit = tx_bit(q.shreg, lsb_first);
      end
      if (q.edges == (EDGES_PER_BYTE - 5'h01)) begin
        d.busy = 1'b0;
        d.edges = 5'h00;
        d.rx_buf = ctl_sample ? shifted : q.shreg;
        d.done = 1'b1;
      end
    end
    if (controller_select && !q.busy) begin
      d.sck_lvl = clock_idle_level;
    end

    // data register write: load the single transmit buffer or flag a collision
    if (wr_data) begin
      if (in_progress) begin
        d.write_collision_flag = 1'b1;
      end else begin
        d.shreg = i_wdata;
        d.out_bit = tx_bit(i_wdata, lsb_first);
        if (en && controller_select) begin
          d.busy = 1'b1;
          d.edges = 5'h00;
          d.sck_lvl = clock_idle_level;
        end
      end
    end

    // select pulled low in controller role: drop to target role
    if (mode_fault) begin
      d.ctrl[CTRL_MASTER] = 1'b0;
      d.done = 1'b1;
      d.busy = 1'b0;
      d.edges = 5'h00;
      d.bitcnt = 4'h0;
    end

    // disabled port: nothing moves
    if (!en) begin
      d.busy = 1'b0;
      d.edges = 5'h00;
      d.bitcnt = 4'h0;
      d.sck_lvl = clock_idle_level;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.dbl <= STAT_RESET[STAT_DOUBLE];
      q.rx_buf <= DATA_RESET;
      q.shreg <= DATA_RESET;
      q.sync <= '1;
      q.filt <= '1;
      q.filt_prev <= '1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rdata = q.rdata;
  assign o_irq = q.done & q.ctrl[CTRL_IRQ_EN] & i_global_irq_en;

  // controller drives sck and mosi, target only miso while selected
  assign o_sck = q.sck_lvl;
  assign o_sck_oe = en & controller_select;
  assign o_mosi = q.out_bit;
  assign o_mosi_oe = en & controller_select;
  assign o_miso = q.out_bit;
  assign o_miso_oe = tgt_active;

endmodule

// File: core/spi_port_pkg.sv
package spi_port_pkg;

  // register map (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_CTRL = 8'h2C;
  localparam logic [7:0] ADDR_STAT = 8'h2D;
  localparam logic [7:0] ADDR_DATA = 8'h2E;

  // control register field positions
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_BIT_ORDER = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_IDLE_LVL = 3;
  localparam int CTRL_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  // status register field positions
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_DOUBLE = 0;

  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT = 4;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_MISO = 3;

  // half of the sck period in system clocks, indexed by {double, hi, lo}
  // full dividers: 4,16,64,128 and doubled 2,8,32,64
  localparam logic [6:0] HALF_PERIOD [8] = '{
    7'h02, 7'h08, 7'h20, 7'h40,
    7'h01, 7'h04, 7'h10, 7'h20
  };

endpackage

// File: core/spi_rate_if.sv
`timescale 1ns/1ps
interface spi_rate_if;
  logic run;
  logic [2:0] rate_code;
  logic tick;

  modport ctrl (
    output run,
    output rate_code,
    input tick
  );

  modport div (
    input run,
    input rate_code,
    output tick
  );
endinterface

// File: core/spi_rate_div.sv
`timescale 1ns/1ps
module spi_rate_div
  import spi_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // rate link to the shift engine
  spi_rate_if.div rate
);

  typedef struct packed {
    logic [6:0] cnt;
  } div_state_t;

  div_state_t q;
  div_state_t d;
  logic [6:0] half;

  assign half = HALF_PERIOD[rate.rate_code];
  // one tick per sck half period while the controller shifts
  assign rate.tick = rate.run & (q.cnt == (half - 7'h01));

  always_comb begin
    d = q;
    if (!rate.run || rate.tick) begin
      d.cnt = 7'h00;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// File: sim/spi_port_properties.sv
`timescale 1ns/1ps
module spi_port_properties
  import spi_port_pkg::*;
(
  // clock, reset, register port
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // core hookup and pins
  input wire logic i_global_irq_en,
  input wire logic i_vector_taken,
  input wire logic o_irq,
  input wire logic i_sel_is_output,
  input wire logic i_sel_n,
  input wire logic o_sck_oe,
  input wire logic o_mosi_oe,
  input wire logic o_miso_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire ctrl_wr = i_wr && i_addr == ADDR_CTRL;
  // controller with select as input, then select held low
  sequence sel_fault;
    o_sck_oe && !i_sel_is_output && i_sel_n ##1 (!i_sel_n && !i_sel_is_output && !i_wr) [*8];
  endsequence
  a_rd_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero");
  a_stat_resv_zero: assert property (i_rd && i_addr == ADDR_STAT |=> o_rdata[5:1] == 5'h00)
    else $error("reserved status bits set");
  a_irq_gate_off: assert property (!i_global_irq_en |-> !o_irq)
    else $error("irq without global enable");
  a_vec_clears: assert property (i_vector_taken |=> !o_irq)
    else $error("irq kept after vector");
  a_dis_no_drive: assert property (ctrl_wr && !i_wdata[CTRL_PORT_EN] |=> !(o_sck_oe || o_mosi_oe || o_miso_oe))
    else $error("pins driven while disabled");
  a_master_drives: assert property (ctrl_wr && i_wdata[6] && i_wdata[4] && i_sel_is_output
    |=> o_sck_oe && o_mosi_oe && !o_miso_oe)
    else $error("controller pins not driven");
  a_sel_hi_quiet: assert property (i_sel_n [*6] |-> !o_miso_oe)
    else $error("miso driven while unselected");
  a_fault_release: assert property (sel_fault |-> !o_sck_oe)
    else $error("controller kept after select low");
  a_target_stays: assert property (!o_sck_oe && !ctrl_wr |=> !o_sck_oe)
    else $error("controller role without write");
endmodule

bind spi_port spi_port_properties spi_port_properties_inst (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_global_irq_en, .i_vector_taken, .o_irq, .i_sel_is_output, .i_sel_n, .o_sck_oe, .o_mosi_oe, .o_miso_oe);

// File: sim/spi_far_model.sv
`timescale 1ns/1ps
module spi_far_model (
  // pins seen by the far target
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  // mode, byte to send, byte taken
  input wire logic i_clock_idle_level,
  input wire logic i_clock_phase_select,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  wire smp = i_sck ^ i_clock_idle_level ^ i_clock_phase_select;
  logic [7:0] sh;
  int n;
  always @(negedge i_sel_n) begin
    sh = i_tx;
    n = 0;
    o_miso = sh[7];
  end
  // a released line shows the inverse of its last bit
  always @(posedge i_sel_n) o_miso = ~o_miso;
  always @(posedge smp) if (!i_sel_n) begin
    o_rx = {o_rx[6:0], i_mosi};
    n++;
  end
  always @(negedge smp) if (!i_sel_n && (!i_clock_phase_select || n > 0)) begin
    sh = sh << 1;
    o_miso = sh[7];
  end
endmodule

// File: sim/spi_master_slave_port_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module spi_master_slave_port_bench;
  import spi_port_pkg::*;
  logic i_clk, i_nrst, i_wr, i_rd, i_global_irq_en, i_vector_taken, i_sel_is_output, i_sel_n;
  logic o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, b_sck, b_mosi, m_miso, clock_idle_level, clock_phase_select, sck_p;
  logic [7:0] i_addr, i_wdata, o_rdata, far_tx, far_rx, d, e;
  int error_cnt = 0;
  int cmp_count = 0;
  int n, t0, t1, cyc;
  // {rate_double, control byte} beside the sck divider it should give
  logic [8:0] row_in [8] = '{9'h051, 9'h076, 9'h05B, 9'h17E, 9'h050, 9'h154, 9'h159, 9'h15F};
  int row_div [8] = '{16, 64, 128, 32, 4, 2, 8, 64};
  wire sck_w = o_sck_oe ? o_sck : b_sck;
  wire mosi_w = o_mosi_oe ? o_mosi : b_mosi;
  wire miso_w = o_miso_oe ? o_miso : m_miso;
  spi_port spi_port_inst (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_global_irq_en,
    .i_vector_taken, .o_irq, .i_sel_is_output, .i_sck(sck_w), .o_sck, .o_sck_oe, .i_mosi(mosi_w), .o_mosi,
    .o_mosi_oe, .i_miso(miso_w), .o_miso, .o_miso_oe, .i_sel_n);
  spi_far_model spi_far_model_inst (.i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n, .i_clock_idle_level(clock_idle_level), .i_clock_phase_select(clock_phase_select),
    .i_tx(far_tx), .o_miso(m_miso), .o_rx(far_rx));
  ////////////////////////////////////////
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    // read data stand in the cycle after the strobe; taken at the edge that ends it
    @(posedge i_clk);
    d = o_rdata;
  endtask
  // bench as outside controller, mode 0, msb first, sck period 16 clocks
  task automatic tbits(input logic [7:0] b, input int k);
    for (int i = 0; i < k; i++) begin
      b_mosi <= b[7 - i];
      repeat (8) @(posedge i_clk);
      d = {d[6:0], miso_w};
      b_sck <= 1'b1;
      repeat (8) @(posedge i_clk);
      b_sck <= 1'b0;
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  // counts sck edges and when the first and last came
  always @(posedge i_clk) begin
    cyc++;
    if (o_sck !== sck_p) begin
      if (n == 0) t0 = cyc;
      t1 = cyc;
      n++;
    end
    sck_p = o_sck;
  end
  initial begin
    {i_nrst, i_wr, i_rd, i_vector_taken, b_sck, b_mosi, clock_idle_level, clock_phase_select} = '0;
    {i_addr, i_wdata, far_tx} = '0;
    {i_global_irq_en, i_sel_is_output, i_sel_n} = 3'h7;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    acc(0, ADDR_CTRL, 0);
    `CHK("ctrl reset", 8'h00, d)
    acc(1, ADDR_STAT, 8'hFF);
    acc(0, ADDR_STAT, 0);
    `CHK("stat bits", 8'h01, d)
    acc(0, 8'h2F, 0);
    `CHK("unmapped", 8'h00, d)
    for (int r = 0; r < 8; r++) begin
      acc(1, ADDR_STAT, {7'h00, row_in[r][8]});
      acc(1, ADDR_CTRL, row_in[r][7:0]);
      clock_idle_level = row_in[r][3];
      clock_phase_select = row_in[r][2];
      far_tx = 8'h3C + 8'(r);
      repeat (3) @(posedge i_clk);
      `CHK("sck idle", row_in[r][3], o_sck)
      n = 0;
      i_sel_n <= 1'b0;
      acc(1, ADDR_DATA, 8'hA5 ^ 8'(r));
      for (int c = 0; c < 2200 && n < 16; c++) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      `CHK("edges", 16, n)
      `CHK("span", 15 * row_div[r] / 2, t1 - t0)
      i_sel_n <= 1'b1;
      acc(0, ADDR_STAT, 0);
      `CHK("done", {1'b1, 6'h00, row_in[r][8]}, d)
      e = 8'hA5 ^ 8'(r);
      if (row_in[r][5]) e = {<<{e}};
      `CHK("far rx", e, far_rx)
      e = far_tx;
      if (row_in[r][5]) e = {<<{e}};
      acc(0, ADDR_DATA, 0);
      if (row_div[r] > 8) `CHK("rx", e, d)
      acc(0, ADDR_STAT, 0);
      `CHK("cleared", {7'h00, row_in[r][8]}, d)
      acc(0, ADDR_CTRL, 0);
      `CHK("role", row_in[r][7:0], d)
    end
    acc(1, ADDR_STAT, 8'h00);
    acc(1, ADDR_CTRL, 8'hD3);
    acc(1, ADDR_DATA, 8'h11);
    acc(1, ADDR_DATA, 8'h22);
    repeat (1100) @(posedge i_clk);
    `CHK("irq", 1'b1, o_irq)
    i_global_irq_en <= 1'b0;
    @(posedge i_clk);
    `CHK("irq masked", 1'b0, o_irq)
    i_global_irq_en <= 1'b1;
    i_vector_taken <= 1'b1;
    @(posedge i_clk);
    i_vector_taken <= 1'b0;
    acc(0, ADDR_STAT, 0);
    `CHK("write_collision_flag", 8'h40, d)
    acc(0, ADDR_DATA, 0);
    acc(0, ADDR_STAT, 0);
    `CHK("flags", 8'h00, d)
    i_sel_is_output <= 1'b0; // select held high meanwhile
    acc(1, ADDR_CTRL, 8'h50);
    i_sel_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    acc(0, ADDR_CTRL, 0);
    `CHK("fault role", 8'h40, d)
    acc(0, ADDR_STAT, 0);
    `CHK("fault flag", 8'h80, d)
    i_sel_n <= 1'b1;
    acc(0, ADDR_DATA, 0);
    repeat (10) @(posedge i_clk);
    acc(0, ADDR_CTRL, 0);
    `CHK("stays", 8'h40, d)
    acc(1, ADDR_STAT, 8'h01);
    acc(1, ADDR_CTRL, 8'h43);
    i_sel_n <= 1'b0;
    tbits(8'hFF, 3);
    i_sel_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    acc(1, ADDR_DATA, 8'h96);
    acc(0, ADDR_STAT, 0);
    `CHK("partial", 8'h01, d)
    i_sel_n <= 1'b0;
    tbits(8'h5A, 8);
    `CHK("miso", 8'h96, d)
    repeat (8) @(posedge i_clk);
    i_sel_n <= 1'b1;
    acc(0, ADDR_STAT, 0);
    `CHK("tgt done", 8'h81, d)
    acc(0, ADDR_DATA, 0);
    `CHK("tgt rx", 8'h5A, d)
    acc(1, ADDR_CTRL, 8'h00);
    i_sel_n <= 1'b0;
    tbits(8'h33, 8);
    i_sel_n <= 1'b1;
    acc(0, ADDR_STAT, 0);
    `CHK("disabled", 8'h01, d)
    close_out();
  end
endmodule
